// ---- design/lsw_pkg.sv ----
// Package for the limit switch enable sequencer: register indices, field layout,
// reset values, slot codes, power states and bus codes.
// Assumes register byte address = 4 * index on a 32-bit AHB-Lite bus.
package lsw_pkg;

  localparam int unsigned LSW_DATA_W = 16;
  localparam int unsigned LSW_IDX_W  = 8;
  localparam int unsigned LSW_IDX_LSB = 2;

  // Register indices
  localparam logic [LSW_IDX_W-1:0] LSW_IDX_POWER_REQUEST  = 8'h0d;
  localparam logic [LSW_IDX_W-1:0] LSW_IDX_SUPPLY_REQUEST = 8'hb0;
  localparam logic [LSW_IDX_W-1:0] LSW_IDX_SWITCH_CTL     = 8'hc7;
  localparam logic [LSW_IDX_W-1:0] LSW_IDX_SWITCH_STATUS  = 8'hd0;

  // Field positions
  localparam int unsigned LSW_REQ_BIT        = 15;
  localparam int unsigned LSW_STARTUP_LSB    = 10;
  localparam int unsigned LSW_SHUTDOWN_LSB   = 6;
  localparam int unsigned LSW_SLOT_W         = 4;
  localparam int unsigned LSW_SLEEP_KEEP_BIT = 4;
  localparam int unsigned LSW_SLEEP_BULK_BIT = 1;
  localparam int unsigned LSW_AWAKE_BULK_BIT = 0;
  localparam int unsigned LSW_STAT_SWITCH_BIT = 0;
  localparam int unsigned LSW_STAT_BULK_BIT   = 1;

  // Reset values
  localparam logic                  LSW_REQ_RESET        = 1'h0;
  localparam logic [LSW_SLOT_W-1:0] LSW_SLOT_RESET       = 4'h0;
  localparam logic                  LSW_SLEEP_KEEP_RESET = 1'h0;
  localparam logic                  LSW_AWAKE_BULK_RESET = 1'h1;
  localparam logic                  LSW_SLEEP_BULK_RESET = 1'h1;

  // Slot codes
  localparam logic [LSW_SLOT_W-1:0] LSW_SLOT_NONE  = 4'h0;
  localparam logic [LSW_SLOT_W-1:0] LSW_SLOT_FIRST = 4'h1;
  localparam logic [LSW_SLOT_W-1:0] LSW_SLOT_LAST  = 4'he;
  localparam logic [LSW_SLOT_W-1:0] LSW_SLOT_ENTRY = 4'hf;

  // AHB-Lite codes
  localparam logic [1:0] LSW_HTRANS_NONSEQ = 2'h2;
  localparam logic       LSW_HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    LSW_PM_OFF,
    LSW_PM_STARTUP,
    LSW_PM_PRE_ACTIVE,
    LSW_PM_ACTIVE,
    LSW_PM_HIBERNATE,
    LSW_PM_SHUTDOWN
  } lsw_pm_state_t;

  function automatic logic lsw_slot_numbered(input logic [LSW_SLOT_W-1:0] code);
    lsw_slot_numbered = (code >= LSW_SLOT_FIRST) && (code <= LSW_SLOT_LAST);
  endfunction

endpackage

// ---- design/lsw_reg_if.sv ----
// Interface between the bus front end and the register/sequencer core.
// Assumes one clock; strobes are single-cycle.
`timescale 1ns/1ps
`default_nettype none
interface lsw_reg_if;
  import lsw_pkg::*;
  logic                  wr_en;
  logic                  rd_en;
  logic [LSW_IDX_W-1:0]  index;
  logic                  mapped;
  logic [LSW_DATA_W-1:0] wdata;
  logic [LSW_DATA_W-1:0] rdata;

  modport front (output wr_en, output rd_en, output index, output wdata, input rdata, input mapped);
  modport core  (input wr_en, input rd_en, input index, input wdata, output rdata, output mapped);
endinterface
`default_nettype wire

// ---- design/lsw_ahb_slave.sv ----
// AHB-Lite slave front end for the limit switch registers.
// Assumes a single slave: hreadyout is the bus hready. Writes take no wait state, reads one.
`timescale 1ns/1ps
`default_nettype none
module lsw_ahb_slave
  import lsw_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  lsw_reg_if.front         regs
);

  typedef enum logic [1:0] {LSW_BUS_IDLE, LSW_BUS_WRITE, LSW_BUS_READ, LSW_BUS_READ_DONE} lsw_bus_state_t;

  lsw_bus_state_t       state;
  lsw_bus_state_t       next_state;
  logic [LSW_IDX_W-1:0] index;
  logic [LSW_IDX_W-1:0] next_index;
  logic                 in_range;
  logic                 next_in_range;
  logic [31:0]          next_hrdata;
  logic                 take;

  // Upper address bits must be zero, otherwise the access is unmapped
  assign take = hsel && (htrans == LSW_HTRANS_NONSEQ) && hready;

  always_comb begin
    next_state    = state;
    next_index    = index;
    next_in_range = in_range;
    next_hrdata   = hrdata;
    unique case (state)
      LSW_BUS_READ: begin
        next_hrdata = (in_range && regs.mapped) ? {16'h0000, regs.rdata} : 32'h0000_0000;
        next_state  = LSW_BUS_READ_DONE;
      end
      default: begin
        next_state = LSW_BUS_IDLE;
        if (take) begin
          next_index    = haddr[LSW_IDX_LSB +: LSW_IDX_W];
          next_in_range = (haddr[31:LSW_IDX_LSB+LSW_IDX_W] == '0) && (haddr[LSW_IDX_LSB-1:0] == '0);
          next_state    = hwrite ? LSW_BUS_WRITE : LSW_BUS_READ;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= LSW_BUS_IDLE;
      index    <= '0;
      in_range <= 1'b0;
      hrdata   <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      index    <= next_index;
      in_range <= next_in_range;
      hrdata   <= next_hrdata;
    end
  end

  // Read waits one cycle so a write just ahead of it is already in the registers
  assign hreadyout   = (state != LSW_BUS_READ);
  assign regs.wr_en  = (state == LSW_BUS_WRITE) && in_range;
  assign regs.rd_en  = (state == LSW_BUS_READ) && in_range;
  assign regs.index  = index;
  assign regs.wdata  = hwdata[LSW_DATA_W-1:0];

endmodule
`default_nettype wire

// ---- design/lsw_sequencer.sv ----
// Limit switch enable sequencer: request bit with two aliases, start-up and shutdown
// slot control, Hibernate handling, bulk detection enable, and its AHB-Lite registers.
// Assumes power state and slot ticks come from logic on hclk, so they are not resynchronised.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module lsw_sequencer
  import lsw_pkg::*;
#(
  parameter logic [LSW_SLOT_W-1:0] STARTUP_PRESET = 4'h0
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [2:0]  pm_state,
  input  wire logic        slot_tick,
  input  wire logic [3:0]  slot_num,
  input  wire logic        dev_mode,
  output logic             switch_enable,
  output logic             bulk_sense_enable
);

  lsw_reg_if regs ();

  lsw_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .regs      (regs)
  );

  // Only whole-word transfers are expected; size is not checked
  assign hresp = LSW_HRESP_OKAY;

  lsw_pm_state_t pm;
  lsw_pm_state_t pm_prev;
  lsw_pm_state_t next_pm_prev;

  assign pm = lsw_pm_state_t'(pm_state);

  // Control register state
  logic                  switch_on_request;
  logic                  next_switch_on_request;
  logic [LSW_SLOT_W-1:0] startup_slot_store;
  logic [LSW_SLOT_W-1:0] next_startup_slot_store;
  logic [LSW_SLOT_W-1:0] shutdown_slot_select;
  logic [LSW_SLOT_W-1:0] next_shutdown_slot_select;
  logic                  sleep_keep_setting;
  logic                  next_sleep_keep_setting;
  logic                  awake_bulk_sense_on;
  logic                  next_awake_bulk_sense_on;
  logic                  sleep_bulk_sense_on;
  logic                  next_sleep_bulk_sense_on;

  // Switch state
  logic                  next_switch_enable;
  logic                  next_bulk_sense_enable;

  logic [LSW_SLOT_W-1:0] startup_slot_select;
  logic                  wr_request;
  logic                  wr_ctl;
  logic                  entering_active;
  logic                  startup_hit;
  logic                  shutdown_hit;
  logic                  hw_set_request;

  // Mode strap comes from a pin, so it passes two flops; until then the custom preset holds
  logic dev_mode_meta;
  logic dev_mode_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_mode_meta <= 1'b0;
      dev_mode_sync <= 1'b0;
    end else begin
      dev_mode_meta <= dev_mode;
      dev_mode_sync <= dev_mode_meta;
    end
  end

  // Custom modes pin the start-up slot to the preset
  assign startup_slot_select = dev_mode_sync ? startup_slot_store : STARTUP_PRESET;

  // Either alias writes the one request flop
  assign wr_request = regs.wr_en &&
                      ((regs.index == LSW_IDX_POWER_REQUEST) || (regs.index == LSW_IDX_SUPPLY_REQUEST));
  assign wr_ctl     = regs.wr_en && (regs.index == LSW_IDX_SWITCH_CTL);

  // Only a start-up reaches Active through this; a wake from Hibernate leaves the request alone
  assign entering_active = (pm == LSW_PM_ACTIVE) && (pm_prev != LSW_PM_ACTIVE) && (pm_prev != LSW_PM_HIBERNATE);

  // A numbered code matches only the tick of its own slot; 0 and 15 never match a tick
  function automatic logic slot_match(input logic                  tick,
                                      input logic [LSW_SLOT_W-1:0] num,
                                      input logic [LSW_SLOT_W-1:0] code);
    slot_match = tick && lsw_slot_numbered(code) && (num == code);
  endfunction

  always_comb begin
    startup_hit  = 1'b0;
    shutdown_hit = 1'b0;
    if (pm == LSW_PM_STARTUP && slot_match(slot_tick, slot_num, startup_slot_select)) begin
      startup_hit = 1'b1;
    end
    if (entering_active && startup_slot_select == LSW_SLOT_ENTRY) begin
      startup_hit = 1'b1;
    end
    if (pm == LSW_PM_SHUTDOWN && slot_match(slot_tick, slot_num, shutdown_slot_select)) begin
      shutdown_hit = 1'b1;
    end
  end

  // Only the start-up sequence sets the request; shutdown leaves it for software to see
  assign hw_set_request = startup_hit;

  // Request bit: the hardware set wins over a software clear in the same cycle
  always_comb begin
    next_switch_on_request = switch_on_request;
    if (wr_request) begin
      next_switch_on_request = regs.wdata[LSW_REQ_BIT];
    end
    if (hw_set_request) begin
      next_switch_on_request = 1'b1;
    end
  end

  always_comb begin
    next_startup_slot_store   = startup_slot_store;
    next_shutdown_slot_select = shutdown_slot_select;
    next_sleep_keep_setting   = sleep_keep_setting;
    next_awake_bulk_sense_on  = awake_bulk_sense_on;
    next_sleep_bulk_sense_on  = sleep_bulk_sense_on;
    if (wr_ctl) begin
      if (dev_mode_sync) begin
        next_startup_slot_store = regs.wdata[LSW_STARTUP_LSB +: LSW_SLOT_W];
      end
      next_shutdown_slot_select = regs.wdata[LSW_SHUTDOWN_LSB +: LSW_SLOT_W];
      next_sleep_keep_setting   = regs.wdata[LSW_SLEEP_KEEP_BIT];
      next_awake_bulk_sense_on  = regs.wdata[LSW_AWAKE_BULK_BIT];
      next_sleep_bulk_sense_on  = regs.wdata[LSW_SLEEP_BULK_BIT];
    end
  end

  // The request bit is its own group: both aliases and the hardware set feed one flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_on_request <= LSW_REQ_RESET;
    end else begin
      switch_on_request <= next_switch_on_request;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      startup_slot_store   <= LSW_SLOT_RESET;
      shutdown_slot_select <= LSW_SLOT_RESET;
      sleep_keep_setting   <= LSW_SLEEP_KEEP_RESET;
      awake_bulk_sense_on  <= LSW_AWAKE_BULK_RESET;
      sleep_bulk_sense_on  <= LSW_SLEEP_BULK_RESET;
    end else begin
      startup_slot_store   <= next_startup_slot_store;
      shutdown_slot_select <= next_shutdown_slot_select;
      sleep_keep_setting   <= next_sleep_keep_setting;
      awake_bulk_sense_on  <= next_awake_bulk_sense_on;
      sleep_bulk_sense_on  <= next_sleep_bulk_sense_on;
    end
  end

  // Power state history, used only to see the step into Active
  always_comb begin
    next_pm_prev = pm;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pm_prev <= LSW_PM_OFF;
    end else begin
      pm_prev <= next_pm_prev;
    end
  end

  // Switch control
  always_comb begin
    next_switch_enable = switch_enable;
    unique case (pm)
      LSW_PM_OFF: begin
        next_switch_enable = 1'b0;
      end
      LSW_PM_STARTUP: begin
        if (startup_hit) begin
          next_switch_enable = 1'b1;
        end
      end
      LSW_PM_PRE_ACTIVE: begin
        // A request made here waits for Active
        next_switch_enable = switch_enable;
      end
      LSW_PM_ACTIVE: begin
        // The next request, so a write lands on the switch at the same edge
        next_switch_enable = next_switch_on_request;
      end
      LSW_PM_HIBERNATE: begin
        // The stored request, so a kept setting is exactly what Active had
        next_switch_enable = sleep_keep_setting ? switch_on_request : 1'b0;
      end
      LSW_PM_SHUTDOWN: begin
        if (shutdown_hit) begin
          next_switch_enable = 1'b0;
        end
      end
      default: begin
        next_switch_enable = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_enable <= 1'b0;
    end else begin
      switch_enable <= next_switch_enable;
    end
  end

  // Bulk detection looks at the switch's next value, so it never lags a switch-on by a cycle
  always_comb begin
    if (next_switch_enable) begin
      next_bulk_sense_enable = 1'b1;
    end else if (pm == LSW_PM_HIBERNATE) begin
      next_bulk_sense_enable = sleep_bulk_sense_on;
    end else begin
      next_bulk_sense_enable = awake_bulk_sense_on;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bulk_sense_enable <= LSW_AWAKE_BULK_RESET;
    end else begin
      bulk_sense_enable <= next_bulk_sense_enable;
    end
  end

  // Register read path; fields not held here read as zero
  always_comb begin
    regs.rdata  = '0;
    regs.mapped = 1'b1;
    unique case (regs.index)
      LSW_IDX_POWER_REQUEST, LSW_IDX_SUPPLY_REQUEST: begin
        regs.rdata[LSW_REQ_BIT] = switch_on_request;
      end
      LSW_IDX_SWITCH_CTL: begin
        regs.rdata[LSW_STARTUP_LSB +: LSW_SLOT_W]  = startup_slot_select;
        regs.rdata[LSW_SHUTDOWN_LSB +: LSW_SLOT_W] = shutdown_slot_select;
        regs.rdata[LSW_SLEEP_KEEP_BIT]             = sleep_keep_setting;
        regs.rdata[LSW_AWAKE_BULK_BIT]             = awake_bulk_sense_on;
        regs.rdata[LSW_SLEEP_BULK_BIT]             = sleep_bulk_sense_on;
      end
      LSW_IDX_SWITCH_STATUS: begin
        // The real switch state, which internal conditions may hold off
        regs.rdata[LSW_STAT_SWITCH_BIT] = switch_enable;
        regs.rdata[LSW_STAT_BULK_BIT]   = bulk_sense_enable;
      end
      default: begin
        regs.mapped = 1'b0;
      end
    endcase
    // Outside a read the mux is parked at zero so idle cycles do not toggle the read path
    if (!regs.rd_en) begin
      regs.rdata = '0;
    end
  end

endmodule
`default_nettype wire

// ---- test/lsw_sequencer_properties.sv ----
// Checker for lsw_sequencer: bus timing and switch/bulk relations at the ports.
// Assumes one clock domain and binding onto every lsw_sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module lsw_sequencer_properties
  import lsw_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [2:0]  pm_state,
  input wire logic        slot_tick,
  input wire logic        switch_enable,
  input wire logic        bulk_sense_enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic taken;
  assign taken = hsel && (htrans == LSW_HTRANS_NONSEQ) && hready;

  bulk_follow_a: assert property (switch_enable |-> bulk_sense_enable)
    else $error("bulk sense off while switch on");
  off_entry_a: assert property (pm_state == LSW_PM_OFF |=> !switch_enable)
    else $error("switch on after OFF state");
  preact_hold_a: assert property (pm_state == LSW_PM_PRE_ACTIVE |=> !$rose(switch_enable))
    else $error("switch turned on in pre-active");
  // Only start-up slots, Active and a kept Hibernate setting may turn the switch on
  rise_cause_a: assert property ($rose(switch_enable) |->
      $past(pm_state) inside {LSW_PM_STARTUP, LSW_PM_ACTIVE, LSW_PM_HIBERNATE})
    else $error("switch rose in wrong power state");
  write_ready_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  rdata_upper_a: assert property ($rose(hreadyout) |-> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  resp_okay_a: assert property (taken |=> hresp == LSW_HRESP_OKAY)
    else $error("response not okay");

  slot_on_c: cover property (slot_tick ##1 $rose(switch_enable));
  read_c: cover property (taken && !hwrite ##2 hreadyout);
  hib_c: cover property (pm_state == LSW_PM_HIBERNATE && !switch_enable && bulk_sense_enable);
endmodule

bind lsw_sequencer lsw_sequencer_properties u_lsw_sequencer_properties (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .pm_state, .slot_tick, .switch_enable, .bulk_sense_enable);
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for lsw_sequencer: registers over AHB-Lite, power states, slots.
// Assumes one 10 MHz clock; hready is fed back from hreadyout, the only slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lsw_pkg::*;
;
  localparam logic [31:0] A_REQ   = {22'h0, LSW_IDX_POWER_REQUEST, 2'h0};
  localparam logic [31:0] A_ALIAS = {22'h0, LSW_IDX_SUPPLY_REQUEST, 2'h0};
  localparam logic [31:0] A_CTL   = {22'h0, LSW_IDX_SWITCH_CTL, 2'h0};
  localparam logic [31:0] A_STAT  = {22'h0, LSW_IDX_SWITCH_STATUS, 2'h0};

  logic        hclk, hresetn, hsel, hwrite, slot_tick, dev_mode;
  logic        hreadyout, hresp, switch_enable, bulk_sense_enable;
  logic [1:0]  htrans;
  logic [2:0]  pm_state;
  logic [3:0]  slot_num;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          miscompares, n_checks, cycles;
  wire logic   hready;
  assign hready = hreadyout;

  lsw_sequencer u_lsw_sequencer (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pm_state, .slot_tick, .slot_num, .dev_mode,
    .switch_enable, .bulk_sense_enable);

  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end

  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang in a bus wait ends here, never in the task itself
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  function automatic logic [31:0] o();
    return {30'h0, bulk_sense_enable, switch_enable};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Waits on hready rather than a fixed count, so a slower answer still passes
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= LSW_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pm(input logic [2:0] s, input int n);
    pm_state <= s;
    step(n);
  endtask

  task automatic tick(input logic [3:0] s);
    slot_tick <= 1'h1;
    slot_num  <= s;
    step(1);
    slot_tick <= 1'h0;
    step(1);
  endtask

  task automatic t_reset;
    chk(o(), 32'h2);
    rchk(A_CTL, 32'h3);
    rchk(A_REQ, 32'h0);
    rchk(A_STAT, 32'h2);
  endtask

  task automatic t_alias;
    pm(LSW_PM_ACTIVE, 3);
    bus(1'h1, A_REQ, 32'h8000);
    step(2);
    chk(o(), 32'h3);
    rchk(A_ALIAS, 32'h8000);
    bus(1'h1, A_ALIAS, 32'h0);
    step(2);
    chk(o(), 32'h2);
    rchk(A_REQ, 32'h0);
    bus(1'h1, 32'h1034, 32'h8000);
    step(2);
    chk(o(), 32'h2);
    rchk(32'h3fc, 32'h0);
    chk({31'h0, hresp}, {31'h0, LSW_HRESP_OKAY});
  endtask

  task automatic t_preact;
    pm(LSW_PM_PRE_ACTIVE, 2);
    bus(1'h1, A_REQ, 32'h8000);
    step(3);
    chk(o(), 32'h2);
    rchk(A_REQ, 32'h8000);
    rchk(A_STAT, 32'h2);
    pm(LSW_PM_ACTIVE, 3);
    chk(o(), 32'h3);
    rchk(A_STAT, 32'h3);
  endtask

  // Every start-up and shutdown code, both fields set alike
  task automatic t_slots;
    logic [3:0] c;
    logic       on;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      pm(LSW_PM_OFF, 2);
      bus(1'h1, A_CTL, {18'h0, c, c, 6'h03});
      bus(1'h1, A_REQ, 32'h0);
      pm(LSW_PM_STARTUP, 1);
      on = 1'h0;
      for (int s = 1; s < 15; s++) begin
        tick(4'(s));
        on = (c != 4'h0) && (c != 4'hf) && (s >= int'(c));
        chk(o(), {30'h0, 1'h1, on});
      end
      rchk(A_REQ, {16'h0, on, 15'h0});
      pm(LSW_PM_PRE_ACTIVE, 2);
      pm(LSW_PM_ACTIVE, 4);
      on = (c != 4'h0);
      chk(o(), {30'h0, 1'h1, on});
      rchk(A_REQ, {16'h0, on, 15'h0});
      pm(LSW_PM_SHUTDOWN, 1);
      for (int s = 1; s < 15; s++) begin
        tick(4'(s));
        chk(o(), {30'h0, 1'h1, on && !(c != 4'hf && s >= int'(c))});
      end
      pm(LSW_PM_OFF, 3);
      chk(o(), 32'h2);
    end
  endtask

  // The mode strap is resynchronised, so each change is given three cycles to settle
  task automatic t_mode;
    bus(1'h1, A_CTL, 32'h3c03);
    rchk(A_CTL, 32'h3c03);
    dev_mode <= 1'h0;
    step(3);
    rchk(A_CTL, 32'h3);
    bus(1'h1, A_CTL, 32'h3);
    dev_mode <= 1'h1;
    step(3);
    rchk(A_CTL, 32'h3c03);
  endtask

  task automatic t_hib;
    pm(LSW_PM_ACTIVE, 3);
    bus(1'h1, A_CTL, 32'h1);
    bus(1'h1, A_REQ, 32'h8000);
    step(2);
    chk(o(), 32'h3);
    pm(LSW_PM_HIBERNATE, 3);
    chk(o(), 32'h0);
    pm(LSW_PM_ACTIVE, 3);
    chk(o(), 32'h3);
    bus(1'h1, A_REQ, 32'h0);
    step(2);
    chk(o(), 32'h2);
    bus(1'h1, A_CTL, 32'h12);
    step(2);
    chk(o(), 32'h0);
    pm(LSW_PM_HIBERNATE, 3);
    chk(o(), 32'h2);
    pm(LSW_PM_ACTIVE, 2);
    bus(1'h1, A_REQ, 32'h8000);
    pm(LSW_PM_HIBERNATE, 3);
    chk(o(), 32'h3);
    pm(LSW_PM_ACTIVE, 2);
    bus(1'h1, A_REQ, 32'h0);
    step(2);
    chk(o(), 32'h0);
  endtask

  initial begin
    hresetn   = 1'h0;
    hsel      = 1'h0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'h0;
    hwdata    = 32'h0;
    pm_state  = LSW_PM_OFF;
    slot_tick = 1'h0;
    slot_num  = 4'h0;
    dev_mode  = 1'h1;
    step(4);
    hresetn <= 1'h1;
    step(1);
    t_reset();
    t_alias();
    t_preact();
    t_slots();
    t_mode();
    t_hib();
    end_sim();
  end
endmodule
`default_nettype wire
